// file: shared/port_sec_pkg.sv
// Function
// - Forward frames only in enabled state
// - Link loss suspends, link return re-enables
// - Frame cut by link loss resumes next frame
// - Securely held address elsewhere suspends port
// - Secured port foreign address suspends port
// - Disable write or init forces management disable
// - Duplication disabled: no forwarding, no learning
// - Mismatch disabled: no forwarding until enable
// - Uplink duplication with violation control disables
// - Uplink never enters any suspended state
// - Six address bytes, security flag bit 40
// - Secured address binds port both ways
// - Uplink address ignores writes, reads zero
// - Secured loads once, unsecured every frame
// - Never duplicate addresses; null the loser
// - Written value sets address and security
// - First byte pauses, last byte resumes learning
// - Status low three bits show state
// - Reset disables; init completion enables ports whose disable bit is clear
package port_sec_pkg;

    // Port population; port zero is the uplink
    localparam int          NUM_PORTS      = 15;
    localparam logic [3:0]  UPLINK_PORT    = 4'h0;

    // Direct I/O port widths
    localparam int          IO_ADDR_W      = 8;
    localparam int          IO_DATA_W      = 8;

    // Per-port register offsets inside each eight-byte port block
    localparam logic [2:0]  OFF_STATUS     = 3'h1;
    localparam logic [2:0]  OFF_ADDR_FIRST = 3'h2;
    localparam logic [2:0]  OFF_ADDR_LAST  = 3'h7;

    // Address register layout
    localparam int          ADDR_W         = 48;
    localparam int          SEC_BIT        = 40;
    localparam logic [47:0] ADDR_RESET     = 48'h0000_0000_0000;
    localparam logic [47:0] ADDR_SEC_MASK  = 48'h0100_0000_0000;

    // Status register field positions
    localparam int          STATUS_NLINK   = 6;
    localparam logic [7:0]  RDATA_RESET    = 8'h00;

    // Port state codes
    typedef enum logic [2:0] {
        ST_ENABLED       = 3'b000,
        ST_SUSP_LINK     = 3'b001,
        ST_SUSP_DUP      = 3'b010,
        ST_SUSP_MISMATCH = 3'b011,
        ST_MGMT_DISABLED = 3'b100,
        ST_RESERVED      = 3'b101,
        ST_DIS_DUP       = 3'b110,
        ST_DIS_MISMATCH  = 3'b111
    } port_state_t;

    // Reset state of every port
    localparam port_state_t STATE_RESET    = ST_MGMT_DISABLED;

endpackage : port_sec_pkg

// file: design/port_state_fsm.sv
`timescale 1ns/1ps
module port_state_fsm #(
    parameter bit IS_UPLINK = 1'b0            // Uplink role of this port
) (
    input  wire logic                      core_clk_in,
    input  wire logic                      rst_n_in,
    input  wire logic                      link_up_in,         // Synchronised link level
    input  wire logic                      viol_disable_in,    // Violation disables rather than suspends
    input  wire logic                      enable_write_in,    // Enable control written with 1
    input  wire logic                      disable_rise_in,    // Disable bit just set
    input  wire logic                      disable_fall_in,    // Disable bit just cleared
    input  wire logic                      disable_bit_in,     // Disable bit level
    input  wire logic                      buf_init_in,        // Buffer initialisation running
    input  wire logic                      init_done_in,       // Initialisation just completed
    input  wire logic                      rx_frame_in,        // Frame received on this port
    input  wire logic                      dup_seen_in,        // Source held securely elsewhere
    input  wire logic                      own_match_in,       // Source equals own address
    input  wire logic                      mismatch_in,        // Secured port saw foreign source
    input  wire logic                      tx_frame_active_in, // Transmit frame in progress
    output port_sec_pkg::port_state_t      state_out,
    output logic                           forward_enable_out,
    output logic                           learn_enable_out,
    output logic                           tx_frame_abort_out
);

    // Whole state of this port
    typedef struct packed {
        port_sec_pkg::port_state_t state;
        logic                      fwd;
        logic                      learn;
        logic                      abort;
    } fsm_state_t;

    fsm_state_t cur;   // Registered copy
    fsm_state_t nxt;   // Next value

    // Next-state logic; management actions take priority over frame events
    always_comb begin
        nxt       = cur;
        nxt.abort = 1'b0;
        if (buf_init_in || disable_rise_in) begin
            nxt.state = port_sec_pkg::ST_MGMT_DISABLED;
        end else if (enable_write_in && cur.state != port_sec_pkg::ST_ENABLED) begin
            nxt.state = port_sec_pkg::ST_ENABLED;
        end else begin
            unique case (cur.state)
                port_sec_pkg::ST_ENABLED: begin
                    if (!link_up_in && !IS_UPLINK) begin
                        nxt.state = port_sec_pkg::ST_SUSP_LINK;
                    end else if (rx_frame_in && dup_seen_in) begin
                        if (IS_UPLINK) begin
                            if (viol_disable_in) begin
                                nxt.state = port_sec_pkg::ST_DIS_DUP;
                            end
                        end else begin
                            nxt.state = viol_disable_in ? port_sec_pkg::ST_DIS_DUP : port_sec_pkg::ST_SUSP_DUP;
                        end
                    end else if (rx_frame_in && mismatch_in && !IS_UPLINK) begin
                        nxt.state = viol_disable_in ? port_sec_pkg::ST_DIS_MISMATCH
                                                    : port_sec_pkg::ST_SUSP_MISMATCH;
                    end
                end
                port_sec_pkg::ST_SUSP_LINK: begin
                    if (link_up_in) begin
                        nxt.state = port_sec_pkg::ST_ENABLED;
                    end
                end
                port_sec_pkg::ST_SUSP_DUP: begin
                    if (rx_frame_in && !dup_seen_in) begin
                        nxt.state = port_sec_pkg::ST_ENABLED;
                    end
                end
                port_sec_pkg::ST_SUSP_MISMATCH: begin
                    if (rx_frame_in && own_match_in) begin
                        nxt.state = port_sec_pkg::ST_ENABLED;
                    end
                end
                port_sec_pkg::ST_MGMT_DISABLED: begin
                    if (disable_fall_in || (init_done_in && !disable_bit_in)) begin
                        nxt.state = port_sec_pkg::ST_ENABLED;
                    end
                end
                port_sec_pkg::ST_RESERVED: begin
                    // Unused code; park safely
                    nxt.state = port_sec_pkg::ST_MGMT_DISABLED;
                end
                port_sec_pkg::ST_DIS_DUP,
                port_sec_pkg::ST_DIS_MISMATCH: begin
                    nxt.state = cur.state;
                end
            endcase
        end
        nxt.abort = cur.fwd && tx_frame_active_in && !link_up_in;
        // forward only enabled; restart at boundary
        if (nxt.state != port_sec_pkg::ST_ENABLED || nxt.abort) begin
            nxt.fwd = 1'b0;
        end else begin
            nxt.fwd = cur.fwd || !tx_frame_active_in;
        end
        nxt.learn = (nxt.state != port_sec_pkg::ST_DIS_DUP);
    end

    // State register
    // reset disables
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cur.state <= port_sec_pkg::STATE_RESET;
            cur.fwd   <= 1'b0;
            cur.learn <= 1'b1;
            cur.abort <= 1'b0;
        end else begin
            cur <= nxt;
        end
    end

    // Outputs straight from the register
    assign state_out          = cur.state;
    assign forward_enable_out = cur.fwd;
    assign learn_enable_out   = cur.learn;
    assign tx_frame_abort_out = cur.abort;

endmodule : port_state_fsm

// file: design/port_security_top.sv
`timescale 1ns/1ps
module port_security_top (
    input  wire logic                                   core_clk_in,
    input  wire logic                                   rst_n_in,
    // Direct I/O port
    input  wire logic [port_sec_pkg::IO_ADDR_W-1:0]     io_addr_in,
    input  wire logic [port_sec_pkg::IO_DATA_W-1:0]     io_wdata_in,
    input  wire logic                                   io_write_in,
    input  wire logic                                   io_read_in,
    output logic      [port_sec_pkg::IO_DATA_W-1:0]     io_rdata_out,
    output logic                                        io_rdata_valid_out,
    // Link pins and management controls
    input  wire logic [port_sec_pkg::NUM_PORTS-1:0]     port_link_input_in,
    input  wire logic                                   secure_violation_disable_in,
    input  wire logic [port_sec_pkg::NUM_PORTS-1:0]     port_enable_write_in,
    input  wire logic [port_sec_pkg::NUM_PORTS-1:0]     port_disable_bit_in,
    input  wire logic                                   buffer_init_active_in,
    // Receive path
    input  wire logic                                   rx_frame_valid_in,
    input  wire logic [3:0]                             rx_frame_port_in,
    input  wire logic [port_sec_pkg::ADDR_W-1:0]        rx_source_address_in,
    // Transmit path
    input  wire logic [port_sec_pkg::NUM_PORTS-1:0]     tx_frame_active_in,
    output logic      [port_sec_pkg::NUM_PORTS-1:0]     port_forward_enable_out,
    output logic      [port_sec_pkg::NUM_PORTS-1:0]     port_learn_enable_out,
    output logic      [port_sec_pkg::NUM_PORTS-1:0]     tx_frame_abort_out
);

    // Register state of the block
    typedef struct packed {
        logic [port_sec_pkg::NUM_PORTS-1:0][port_sec_pkg::ADDR_W-1:0] addr;
        logic [port_sec_pkg::NUM_PORTS-1:0]                           dyn_ok;
        logic [port_sec_pkg::NUM_PORTS-1:0]                           link_meta;
        logic [port_sec_pkg::NUM_PORTS-1:0]                           link_sync;
        logic [port_sec_pkg::NUM_PORTS-1:0]                           disable_prev;
        logic                                                         init_prev;
        logic [port_sec_pkg::IO_DATA_W-1:0]                           rdata;
        logic                                                         rvalid;
    } top_state_t;

    top_state_t cur;    // Registered copy
    top_state_t nxt;    // Next value

    // Address decode of the direct I/O port
    logic [3:0]  io_port;         // Port number field
    logic [2:0]  io_off;          // Register within port block
    logic        io_port_ok;      // Port number exists
    logic        io_addr_sel;     // Offset is an address byte
    logic [2:0]  io_lane;         // Byte lane, zero is bits 7..0

    assign io_port     = io_addr_in[6:3];
    assign io_off      = io_addr_in[2:0];
    assign io_port_ok  = !io_addr_in[7] && (io_port < 4'(port_sec_pkg::NUM_PORTS));
    assign io_addr_sel = (io_off >= port_sec_pkg::OFF_ADDR_FIRST);
    assign io_lane     = 3'(port_sec_pkg::OFF_ADDR_LAST - io_off);

    // Receive port validity; uplink frames never load an address
    logic rx_port_ok;
    assign rx_port_ok = rx_frame_valid_in && (rx_frame_port_in < 4'(port_sec_pkg::NUM_PORTS));

    // Initialisation completes on the falling edge of the init level
    logic init_done;
    assign init_done = cur.init_prev && !buffer_init_active_in;

    // Per-port comparison vectors
    logic [port_sec_pkg::NUM_PORTS-1:0] match_vec;       // Stored address equals frame source
    logic [port_sec_pkg::NUM_PORTS-1:0] sec_vec;         // Security flag of each port
    logic [port_sec_pkg::NUM_PORTS-1:0] nz_vec;          // Port holds a nonnull address
    logic [port_sec_pkg::NUM_PORTS-1:0] secure_else;     // Source held securely by another port
    logic [port_sec_pkg::NUM_PORTS-1:0] rx_hit;          // Frame arrives on this port
    logic [port_sec_pkg::NUM_PORTS-1:0] learn_vec;       // Learning allowed by port state
    logic [port_sec_pkg::NUM_PORTS-1:0] fwd_vec;         // Forward enables from the state machines
    logic [port_sec_pkg::NUM_PORTS-1:0] abort_vec;       // Transmit abort pulses
    port_sec_pkg::port_state_t [port_sec_pkg::NUM_PORTS-1:0] state_vec;
    logic [port_sec_pkg::NUM_PORTS-1:0][port_sec_pkg::ADDR_W-1:0] addr_next;

    // Frame source with the flag position masked out of compares
    logic [port_sec_pkg::ADDR_W-1:0] rx_sa_key;
    assign rx_sa_key = rx_source_address_in & ~port_sec_pkg::ADDR_SEC_MASK;

    // Non-uplink receiving port has learning allowed and no secure holder elsewhere; decides who gets nulled
    logic rx_takes;
    assign rx_takes = rx_port_ok && (rx_frame_port_in != port_sec_pkg::UPLINK_PORT)
                      && cur.dyn_ok[rx_frame_port_in] && learn_vec[rx_frame_port_in]
                      && !secure_else[rx_frame_port_in];

    // Per-port logic: compares, address update and state machine
    genvar p;
    generate
        for (p = 0; p < port_sec_pkg::NUM_PORTS; p++) begin : g_port
            localparam logic [port_sec_pkg::NUM_PORTS-1:0] OWN_BIT = 15'h0001 << p;
            localparam bit UPL = (p == 0);

            assign sec_vec[p]   = cur.addr[p][port_sec_pkg::SEC_BIT];
            assign nz_vec[p]    = |(cur.addr[p] & ~port_sec_pkg::ADDR_SEC_MASK);
            assign match_vec[p] = nz_vec[p] && ((cur.addr[p] & ~port_sec_pkg::ADDR_SEC_MASK) == rx_sa_key);
            assign secure_else[p] = |(match_vec & sec_vec & ~OWN_BIT);
            assign rx_hit[p]      = rx_port_ok && (rx_frame_port_in == 4'(p));

            // Next address of this port; register writes win over learning
            always_comb begin
                addr_next[p] = cur.addr[p];
                if (UPL) begin
                    addr_next[p] = port_sec_pkg::ADDR_RESET;
                end else if (io_write_in && io_port_ok && io_port == 4'(p) && io_addr_sel) begin
                    addr_next[p][{io_lane, 3'b000} +: 8] = io_wdata_in;
                end else if (rx_hit[p] && cur.dyn_ok[p] && learn_vec[p]) begin
                    if (secure_else[p]) begin
                        addr_next[p] = cur.addr[p] & port_sec_pkg::ADDR_SEC_MASK;
                    end else if (!sec_vec[p] || !nz_vec[p]) begin
                        addr_next[p] = rx_sa_key | (cur.addr[p] & port_sec_pkg::ADDR_SEC_MASK);
                    end
                end else if (rx_takes && !rx_hit[p] && match_vec[p] && !sec_vec[p]) begin
                    addr_next[p] = cur.addr[p] & port_sec_pkg::ADDR_SEC_MASK;
                end
            end

            // Port state machine, fed with this port's events
            port_state_fsm #(
                .IS_UPLINK          (UPL)
            ) u_fsm (
                .core_clk_in        (core_clk_in),
                .rst_n_in           (rst_n_in),
                .link_up_in         (cur.link_sync[p]),
                .viol_disable_in    (secure_violation_disable_in),
                .enable_write_in    (port_enable_write_in[p]),
                .disable_rise_in    (port_disable_bit_in[p] && !cur.disable_prev[p]),
                .disable_fall_in    (!port_disable_bit_in[p] && cur.disable_prev[p]),
                .disable_bit_in     (port_disable_bit_in[p]),
                .buf_init_in        (buffer_init_active_in),
                .init_done_in       (init_done),
                .rx_frame_in        (rx_hit[p]),
                .dup_seen_in        (secure_else[p]),
                .own_match_in       (match_vec[p]),
                .mismatch_in        (sec_vec[p] && nz_vec[p] && !match_vec[p] && !secure_else[p]),
                .tx_frame_active_in (tx_frame_active_in[p]),
                .state_out          (state_vec[p]),
                .forward_enable_out (fwd_vec[p]),
                .learn_enable_out   (learn_vec[p]),
                .tx_frame_abort_out (abort_vec[p])
            );
        end
    endgenerate

    // Read data for the addressed register; unmapped reads give zero
    logic [port_sec_pkg::IO_DATA_W-1:0] read_value;
    always_comb begin
        read_value = port_sec_pkg::RDATA_RESET;
        if (io_port_ok) begin
            if (io_off == port_sec_pkg::OFF_STATUS) begin
                read_value[2:0]                        = state_vec[io_port];
                read_value[port_sec_pkg::STATUS_NLINK] = !cur.link_sync[io_port];
            end else if (io_addr_sel) begin
                read_value = cur.addr[io_port][{io_lane, 3'b000} +: 8];
            end
        end
    end

    // Next-state of the block registers
    always_comb begin
        nxt              = cur;
        nxt.addr         = addr_next;
        // Link pins cross in; the first stage feeds only the second
        nxt.link_meta    = port_link_input_in;
        nxt.link_sync    = cur.link_meta;
        nxt.disable_prev = port_disable_bit_in;
        nxt.init_prev    = buffer_init_active_in;
        nxt.rvalid       = io_read_in;
        if (io_read_in) begin
            nxt.rdata = read_value;
        end
        if (io_write_in && io_port_ok) begin
            if (io_off == port_sec_pkg::OFF_ADDR_FIRST) begin
                nxt.dyn_ok[io_port] = 1'b0;
            end else if (io_off == port_sec_pkg::OFF_ADDR_LAST) begin
                nxt.dyn_ok[io_port] = 1'b1;
            end
        end
    end

    // Block registers; learning starts allowed, addresses start null
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cur.addr         <= '0;
            cur.dyn_ok       <= '1;
            cur.link_meta    <= '0;
            cur.link_sync    <= '0;
            cur.disable_prev <= '0;
            cur.init_prev    <= 1'b0;
            cur.rdata        <= port_sec_pkg::RDATA_RESET;
            cur.rvalid       <= 1'b0;
        end else begin
            cur <= nxt;
        end
    end

    // Outputs straight from flip-flops
    assign io_rdata_out            = cur.rdata;
    assign io_rdata_valid_out      = cur.rvalid;
    assign port_forward_enable_out = fwd_vec;
    assign port_learn_enable_out   = learn_vec;
    assign tx_frame_abort_out      = abort_vec;

endmodule : port_security_top

// file: tb/port_security_props.sv
`timescale 1ns/1ps
module port_security_props (
    input wire logic        core_clk_in,
    input wire logic        rst_n_in,
    input wire logic [7:0]  io_addr_in,
    input wire logic        io_read_in,
    input wire logic [7:0]  io_rdata_out,
    input wire logic        io_rdata_valid_out,
    input wire logic        buffer_init_active_in,
    input wire logic [14:0] port_disable_bit_in,
    input wire logic [14:0] tx_frame_active_in,
    input wire logic [14:0] port_forward_enable_out,
    input wire logic [14:0] port_learn_enable_out,
    input wire logic [14:0] tx_frame_abort_out
);
    // One domain, so one clock and one reset for all
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rst_n_in);
    // Read request and its answer
    sequence rd_req; io_read_in; endsequence
    sequence rd_ans; io_rdata_valid_out; endsequence
    chk_read_answer: assert property (rd_req |=> rd_ans)
        else $error("read not answered");
    chk_valid_cause: assert property (rd_ans |-> $past(io_read_in))
        else $error("read valid without request");
    chk_uplink_zero: assert property (rd_req and io_addr_in[7:3] == 5'h00 && io_addr_in[2:0] >= 3'h2
        |=> io_rdata_out == 8'h00) else $error("uplink address not zero");
    chk_init_halt: assert property (buffer_init_active_in |=> port_forward_enable_out == 15'h0000)
        else $error("forwarding during init");
    chk_init_learn: assert property (buffer_init_active_in |=> &port_learn_enable_out)
        else $error("learning off outside duplication disable");
    chk_disable_halt: assert property ($rose(port_disable_bit_in[3]) |=> !port_forward_enable_out[3])
        else $error("disable did not stop forwarding");
    chk_abort_pulse: assert property (tx_frame_abort_out[6] |=> !tx_frame_abort_out[6])
        else $error("abort longer than one cycle");
    chk_abort_cause: assert property (tx_frame_abort_out[6]
        |-> $past(tx_frame_active_in[6]) && $past(port_forward_enable_out[6])) else $error("abort without frame");
    chk_fwd_boundary: assert property ($rose(port_forward_enable_out[6]) |-> !$past(tx_frame_active_in[6]))
        else $error("forwarding resumed mid frame");
endmodule : port_security_props
bind port_security_top port_security_props u_props (.core_clk_in, .rst_n_in, .io_addr_in, .io_read_in,
    .io_rdata_out, .io_rdata_valid_out, .buffer_init_active_in, .port_disable_bit_in, .tx_frame_active_in,
    .port_forward_enable_out, .port_learn_enable_out, .tx_frame_abort_out);

// file: tb/port_host_model.sv
`timescale 1ns/1ps
module port_host_model (
    input  wire logic       core_clk_in,
    output logic      [7:0] io_addr_out,
    output logic      [7:0] io_wdata_out,
    output logic            io_write_out,
    output logic            io_read_out,
    input  wire logic [7:0] io_rdata_in,
    input  wire logic       io_rdata_valid_in
);
    // Quiet bus from time zero
    initial begin
        io_addr_out = 8'h00;
        io_wdata_out = 8'h00;
        io_write_out = 1'b0;
        io_read_out = 1'b0;
    end
    // One byte write, strobe held for one edge
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk_in);
        io_addr_out <= a;
        io_wdata_out <= d;
        io_write_out <= 1'b1;
        @(posedge core_clk_in);
        io_write_out <= 1'b0;
        // Stale data must never pass for valid
        io_wdata_out <= ~d;
    endtask : wr
    // One byte read; unknown unless valid arrives on time
    task rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk_in);
        io_addr_out <= a;
        io_read_out <= 1'b1;
        @(posedge core_clk_in);
        io_read_out <= 1'b0;
        #1;
        d = (io_rdata_valid_in === 1'b1) ? io_rdata_in : 8'hxx;
    endtask : rd
    task wa(input logic [3:0] p, input logic [47:0] v);
        for (int i = 0; i < 6; i++) wr({1'b0, p, 3'(i + 2)}, v[47 - 8 * i -: 8]);
    endtask : wa
endmodule : port_host_model

// file: tb/port_security_top_tb.sv
`timescale 1ns/1ps
module port_security_top_tb;
    logic core_clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic [7:0] io_addr_in, io_wdata_in, io_rdata_out;
    logic io_write_in, io_read_in, io_rdata_valid_out;
    logic [14:0] link = 15'h7FFF, en_w = 15'h0000, dis = 15'h0004, tx = 15'h0000;
    logic [14:0] fwd, learn, abort;
    logic viol_dis = 1'b0, init = 1'b1, rx_v = 1'b0;
    logic [3:0] rx_p = 4'h0;
    logic [47:0] rx_s = 48'h0000_0000_0000;
    logic [47:0] own = 48'h0212_3456_789A; // Port 1 address, flag clear
    int fails = 0, check_count = 0;
    always #2.5 core_clk_in = ~core_clk_in;
    port_host_model h (.core_clk_in, .io_addr_out(io_addr_in), .io_wdata_out(io_wdata_in),
        .io_write_out(io_write_in), .io_read_out(io_read_in), .io_rdata_in(io_rdata_out),
        .io_rdata_valid_in(io_rdata_valid_out));
    port_security_top uut (.core_clk_in, .rst_n_in, .io_addr_in, .io_wdata_in, .io_write_in, .io_read_in,
        .io_rdata_out, .io_rdata_valid_out, .port_link_input_in(link), .secure_violation_disable_in(viol_dis),
        .port_enable_write_in(en_w), .port_disable_bit_in(dis), .buffer_init_active_in(init),
        .rx_frame_valid_in(rx_v), .rx_frame_port_in(rx_p), .rx_source_address_in(rx_s),
        .tx_frame_active_in(tx), .port_forward_enable_out(fwd), .port_learn_enable_out(learn),
        .tx_frame_abort_out(abort));
    task close_out;
        $display("Counts: made %0d bad %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : close_out
    task cmp(input logic [7:0] d, input logic [7:0] e);
        check_count++;
        if (d !== e) begin
            fails++;
            $display("BAD at %0t: got %h want %h", $time, d, e);
        end
    endtask : cmp
    task chk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        h.rd(a, d);
        cmp(d, e);
    endtask : chk
    task step(input int n);
        repeat (n) @(posedge core_clk_in);
    endtask : step
    // One received source address
    task rx(input logic [3:0] p, input logic [47:0] s);
        @(posedge core_clk_in);
        rx_v <= 1'b1;
        rx_p <= p;
        rx_s <= s;
        @(posedge core_clk_in);
        rx_v <= 1'b0;
    endtask : rx
    task en(input int p);
        @(posedge core_clk_in);
        en_w <= 15'h0001 << p;
        @(posedge core_clk_in);
        en_w <= 15'h0000;
    endtask : en
    // Hang guard, far beyond the roughly 140 cycles of the sequence
    initial begin
        #200000;
        fails++;
        close_out;
    end
    initial begin
        step(8);
        rst_n_in <= 1'b1;
        step(4);
        chk(8'h09, 8'h04);
        init <= 1'b0;
        step(2);
        chk(8'h09, 8'h00);
        chk(8'h11, 8'h04);
        dis <= 15'h0008;
        step(2);
        chk(8'h11, 8'h00);
        chk(8'h19, 8'h04);
        en(3);
        chk(8'h19, 8'h00);
        tx <= 15'h0040;
        link <= 15'h7FBF;
        step(4);
        cmp({7'h00, fwd[6]}, 8'h00);
        chk(8'h31, 8'h41);
        tx <= 15'h0000;
        link <= 15'h7FFF;
        step(4);
        chk(8'h31, 8'h00);
        cmp({7'h00, fwd[6]}, 8'h01);
        h.wa(4'h1, 48'h0312_3456_789A);
        chk(8'h0A, 8'h03);
        chk(8'h0F, 8'h9A);
        rx(4'h4, own);
        chk(8'h21, 8'h02);
        chk(8'h27, 8'h00);
        rx(4'h4, 48'h0000_0000_0055);
        chk(8'h21, 8'h00);
        chk(8'h27, 8'h55);
        rx(4'h4, 48'h0000_0000_0066);
        chk(8'h27, 8'h66);
        rx(4'h5, 48'h0000_0000_0066);
        chk(8'h27, 8'h00);
        chk(8'h2F, 8'h66);
        for (int i = 2; i < 7; i++) h.wr({5'h05, 3'(i)}, 8'h00);
        rx(4'h5, 48'h0000_0000_0088);
        chk(8'h2F, 8'h66);
        h.wr(8'h2F, 8'h66);
        rx(4'h5, 48'h0000_0000_0088);
        chk(8'h2F, 8'h88);
        rx(4'h1, 48'h0000_0000_0077);
        chk(8'h09, 8'h03);
        chk(8'h0F, 8'h9A);
        rx(4'h1, own);
        chk(8'h09, 8'h00);
        rx(4'h0, own);
        chk(8'h01, 8'h00);
        viol_dis <= 1'b1;
        rx(4'h0, own);
        chk(8'h01, 8'h06);
        rx(4'h4, own);
        chk(8'h21, 8'h06);
        cmp({7'h00, learn[4]}, 8'h00);
        rx(4'h1, 48'h0000_0000_0077);
        chk(8'h09, 8'h07);
        rx(4'h1, own);
        chk(8'h09, 8'h07);
        en(1);
        chk(8'h09, 8'h00);
        h.wr(8'h02, 8'hFF);
        chk(8'h02, 8'h00);
        close_out;
    end
endmodule : port_security_top_tb
